// >>> logic/dual_legacy_counter_timer.sv
// dual legacy counter/timer with control, mode and count registers
//
// Behaviour
// - 13-bit mode: high byte, low bits 4..0
// - 13-bit rollover sets unit overflow flag
// - counter select counts falling pin edges
// - clock select picks system or prescaled clock
// - outside split mode, count only when run and gate allow
// - setting run keeps the count value
// - unit b mirrors unit a with own bits
// - mode 1 counts all sixteen bits
// - mode 2 reloads low from high byte
// - split mode low byte uses unit a bits
// - split high byte: timer, unit b run/flag
// - unit b internal only, no flag, tick out
// - unit b runs unless its mode is 3
// - overflow flags set, cleared by sw or vector
// - edge/level external interrupt flag behaviour
// - type bit selects level or edge trigger
// - mode field decode per unit
// - mode register gate/select bit positions
// - control register layout, reset zero
// - prescale 12, 4, 48, or external by 8
`timescale 1ns/100ps
`include "legacy_timer_regs.svh"

module dual_legacy_counter_timer
(
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic clk_en_in,
  input wire logic [7:0] addr_in,
  input wire legacy_timer_pkg::byte_type wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output legacy_timer_pkg::byte_type rdata_out,
  input wire logic count_pin_a_in,
  input wire logic count_pin_b_in,
  input wire logic gate_input_a_in,
  input wire logic gate_input_b_in,
  input wire logic ext_clk_in,
  input wire logic vector_a_in,
  input wire logic vector_b_in,
  input wire logic vector_irq_a_in,
  input wire logic vector_irq_b_in,
  output logic baud_tick_out,
  output logic unit_a_overflow_flag_out,
  output logic unit_b_overflow_flag_out,
  output logic ext_irq_a_flag_out,
  output logic ext_irq_b_flag_out
);
  import legacy_timer_pkg::*;

  // ==========================================================
  // registers
  byte_type control_q, control_d;
  byte_type mode_q;
  byte_type clock_cfg_q;
  byte_type pin_cfg_q;
  byte_type a_low_q, a_low_d, a_high_q, a_high_d;
  byte_type b_low_q, b_low_d, b_high_q, b_high_d;
  byte_type rdata_q;
  logic baud_q;
  // synchronisers: [0] first stage, [1] second, [2] previous sample
  logic [2:0] cnt_a_sync_q, cnt_b_sync_q, gate_a_sync_q, gate_b_sync_q, ext_sync_q;
  logic [5:0] div4_q, div12_q, div48_q, div8_q;

  // ==========================================================
  // register decode
  wire wr_control = wr_in && (addr_in == `OFS_CONTROL);
  wire wr_mode = wr_in && (addr_in == `OFS_MODE);
  wire wr_a_low = wr_in && (addr_in == `OFS_A_LOW);
  wire wr_b_low = wr_in && (addr_in == `OFS_B_LOW);
  wire wr_a_high = wr_in && (addr_in == `OFS_A_HIGH);
  wire wr_b_high = wr_in && (addr_in == `OFS_B_HIGH);
  wire wr_clock = wr_in && (addr_in == `OFS_CLOCK_CFG);
  wire wr_pin = wr_in && (addr_in == `OFS_PIN_CFG);

  timer_mode_type mode_a, mode_b;
  assign mode_a = timer_mode_type'(mode_q[`MOD_A_LSB +: 2]);
  assign mode_b = timer_mode_type'(mode_q[`MOD_B_LSB +: 2]);
  wire split_on = (mode_a == mode_split);

  // ==========================================================
  // pin sampling; only stages [1] and [2] feed logic
  wire cnt_a_fall = cnt_a_sync_q[2] && !cnt_a_sync_q[1];
  wire cnt_b_fall = cnt_b_sync_q[2] && !cnt_b_sync_q[1];
  wire ext_fall = ext_sync_q[2] && !ext_sync_q[1];
  // polarity from pin config, active level per unit
  wire gate_a_active = gate_a_sync_q[1] == pin_cfg_q[`PIN_A_POL];
  wire gate_b_active = gate_b_sync_q[1] == pin_cfg_q[`PIN_B_POL];
  wire gate_a_prev = gate_a_sync_q[2] == pin_cfg_q[`PIN_A_POL];
  wire gate_b_prev = gate_b_sync_q[2] == pin_cfg_q[`PIN_B_POL];

  // ==========================================================
  // prescaler taps, one system cycle each
  wire tick_div4 = div4_q == (`DIV_BY_4 - 6'd1);
  wire tick_div48 = div48_q == (`DIV_BY_48 - 6'd1);
  wire tick_div12 = div12_q == (`DIV_BY_12 - 6'd1);
  wire tick_ext8 = ext_fall && div8_q == (`DIV_BY_8 - 6'd1);
  logic pre_tick;
  always_comb
  begin
    unique case (clock_cfg_q[`CKC_PRE_LSB +: 2])
      2'b00: pre_tick = tick_div12;
      2'b01: pre_tick = tick_div4;
      2'b10: pre_tick = tick_div48;
      2'b11: pre_tick = tick_ext8;
    endcase
  end

  // ==========================================================
  // timer clock select per unit
  wire tmr_a_tick = clock_cfg_q[`CKC_A_SYS] ? 1'b1 : pre_tick;
  wire tmr_b_tick = clock_cfg_q[`CKC_B_SYS] ? 1'b1 : pre_tick;
  // counter select picks pin falling edge
  wire src_a = mode_q[`MOD_A_CNT] ? cnt_a_fall : tmr_a_tick;
  // unit b ignores its pin while split
  wire src_b = (mode_q[`MOD_B_CNT] && !split_on) ? cnt_b_fall : tmr_b_tick;
  wire en_a = control_q[`CTL_A_RUN] && (!mode_q[`MOD_A_GATE] || gate_a_active);
  // unit b uses its own run, gate and polarity
  wire en_b_norm = control_q[`CTL_B_RUN] && (!mode_q[`MOD_B_GATE] || gate_b_active);
  // in split, unit b runs on mode 0..2
  wire en_b = split_on ? (mode_b != mode_split) : en_b_norm;
  wire inc_a = en_a && src_a;
  wire inc_b = en_b && src_b && (mode_b != mode_split);
  // split high byte, system/prescaled, unit b run
  wire inc_a_high = split_on && control_q[`CTL_B_RUN] && tmr_a_tick;

  // ==========================================================
  // count unit a
  logic ovf_a, ovf_a_high;
  always_comb
  begin
    a_low_d = a_low_q;
    a_high_d = a_high_q;
    ovf_a = 1'b0;
    ovf_a_high = 1'b0;
    // counts move only on events, never on run set
    if (inc_a)
    begin
      unique case (mode_a)
        // five low bits carry into high byte
        mode_13bit:
        begin
          a_low_d = {a_low_q[7:5], a_low_q[4:0] + 5'd1};
          if (a_low_q[4:0] == 5'h1f)
          begin
            a_high_d = a_high_q + 8'h01;
            ovf_a = (a_high_q == 8'hff);
          end
        end
        mode_16bit:
        begin
          {a_high_d, a_low_d} = {a_high_q, a_low_q} + 16'h0001;
          ovf_a = ({a_high_q, a_low_q} == 16'hffff);
        end
        mode_8bit_reload:
        begin
          ovf_a = (a_low_q == 8'hff);
          a_low_d = ovf_a ? a_high_q : a_low_q + 8'h01;
        end
        // low half on unit a controls
        mode_split:
        begin
          a_low_d = a_low_q + 8'h01;
          ovf_a = (a_low_q == 8'hff);
        end
      endcase
    end
    if (inc_a_high)
    begin
      a_high_d = a_high_q + 8'h01;
      ovf_a_high = (a_high_q == 8'hff);
    end
    if (wr_a_low)
      a_low_d = wdata_in;
    if (wr_a_high)
      a_high_d = wdata_in;
  end

  // ==========================================================
  // count unit b, same modes, mode 3 holds
  logic ovf_b;
  always_comb
  begin
    b_low_d = b_low_q;
    b_high_d = b_high_q;
    ovf_b = 1'b0;
    if (inc_b)
    begin
      unique case (mode_b)
        mode_13bit:
        begin
          b_low_d = {b_low_q[7:5], b_low_q[4:0] + 5'd1};
          if (b_low_q[4:0] == 5'h1f)
          begin
            b_high_d = b_high_q + 8'h01;
            ovf_b = (b_high_q == 8'hff);
          end
        end
        mode_16bit:
        begin
          {b_high_d, b_low_d} = {b_high_q, b_low_q} + 16'h0001;
          ovf_b = ({b_high_q, b_low_q} == 16'hffff);
        end
        mode_8bit_reload:
        begin
          ovf_b = (b_low_q == 8'hff);
          b_low_d = ovf_b ? b_high_q : b_low_q + 8'h01;
        end
        mode_split:
        begin
          ovf_b = 1'b0;
        end
      endcase
    end
    if (wr_b_low)
      b_low_d = wdata_in;
    if (wr_b_high)
      b_high_d = wdata_in;
  end

  // ==========================================================
  // control register next value; set beats any clear
  // in split, unit b overflow never touches its flag
  wire set_b_flag = split_on ? ovf_a_high : ovf_b;
  // edge mode catches the move into active level
  wire edge_a = gate_a_active && !gate_a_prev;
  wire edge_b = gate_b_active && !gate_b_prev;
  logic irq_a_next, irq_b_next;
  always_comb
  begin
    control_d = control_q;
    if (wr_control)
      control_d = wdata_in;
    if (vector_a_in)
      control_d[`CTL_A_FLAG] = 1'b0;
    if (vector_b_in)
      control_d[`CTL_B_FLAG] = 1'b0;
    if (ovf_a)
      control_d[`CTL_A_FLAG] = 1'b1;
    if (set_b_flag)
      control_d[`CTL_B_FLAG] = 1'b1;
    // edge flags cleared on vector, level follows pin
    irq_a_next = control_d[`CTL_A_IRQ_FLAG] && !vector_irq_a_in;
    irq_b_next = control_d[`CTL_B_IRQ_FLAG] && !vector_irq_b_in;
    // type bit zero is level, one is edge
    control_d[`CTL_A_IRQ_FLAG] = control_q[`CTL_A_IRQ_TYPE] ?
      (irq_a_next || edge_a) : gate_a_active;
    control_d[`CTL_B_IRQ_FLAG] = control_q[`CTL_B_IRQ_TYPE] ?
      (irq_b_next || edge_b) : gate_b_active;
  end

  // read mux; unmapped addresses read zero
  byte_type rd_mux;
  always_comb
  begin
    unique case (addr_in)
      `OFS_CONTROL: rd_mux = control_q;
      `OFS_MODE: rd_mux = mode_q;
      `OFS_A_LOW: rd_mux = a_low_q;
      `OFS_B_LOW: rd_mux = b_low_q;
      `OFS_A_HIGH: rd_mux = a_high_q;
      `OFS_B_HIGH: rd_mux = b_high_q;
      `OFS_CLOCK_CFG: rd_mux = clock_cfg_q;
      `OFS_PIN_CFG: rd_mux = pin_cfg_q;
      default: rd_mux = `RST_BYTE;
    endcase
  end

  // ==========================================================
  // synchronise pins and step prescalers
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      cnt_a_sync_q <= 3'b111;
      cnt_b_sync_q <= 3'b111;
      gate_a_sync_q <= 3'b111; // inactive level under active-low default
      gate_b_sync_q <= 3'b111; // so no false edge or level flag after reset
      ext_sync_q <= 3'b000;
      div4_q <= 6'd0;
      div12_q <= 6'd0;
      div48_q <= 6'd0;
      div8_q <= 6'd0;
    end
    else if (clk_en_in)
    begin
      cnt_a_sync_q <= {cnt_a_sync_q[1:0], count_pin_a_in};
      cnt_b_sync_q <= {cnt_b_sync_q[1:0], count_pin_b_in};
      gate_a_sync_q <= {gate_a_sync_q[1:0], gate_input_a_in};
      gate_b_sync_q <= {gate_b_sync_q[1:0], gate_input_b_in};
      ext_sync_q <= {ext_sync_q[1:0], ext_clk_in};
      div4_q <= tick_div4 ? 6'd0 : div4_q + 6'd1;
      div12_q <= tick_div12 ? 6'd0 : div12_q + 6'd1;
      div48_q <= tick_div48 ? 6'd0 : div48_q + 6'd1;
      if (ext_fall)
        div8_q <= (div8_q == (`DIV_BY_8 - 6'd1)) ? 6'd0 : div8_q + 6'd1;
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      control_q <= `RST_BYTE;
      mode_q <= `RST_BYTE;
      clock_cfg_q <= `RST_BYTE;
      pin_cfg_q <= `RST_BYTE;
      a_low_q <= `RST_BYTE;
      a_high_q <= `RST_BYTE;
      b_low_q <= `RST_BYTE;
      b_high_q <= `RST_BYTE;
      rdata_q <= `RST_BYTE;
      baud_q <= 1'b0;
    end
    else if (clk_en_in)
    begin
      control_q <= control_d;
      if (wr_mode)
        mode_q <= wdata_in;
      if (wr_clock)
        clock_cfg_q <= wdata_in;
      if (wr_pin)
        pin_cfg_q <= wdata_in;
      a_low_q <= a_low_d;
      a_high_q <= a_high_d;
      b_low_q <= b_low_d;
      b_high_q <= b_high_d;
      rdata_q <= rd_in ? rd_mux : `RST_BYTE;
      // unit b overflow always reaches serial ports
      baud_q <= ovf_b;
    end
  end

  // ==========================================================
  // outputs straight from flops
  assign rdata_out = rdata_q;
  assign baud_tick_out = baud_q;
  assign unit_a_overflow_flag_out = control_q[`CTL_A_FLAG];
  assign unit_b_overflow_flag_out = control_q[`CTL_B_FLAG];
  assign ext_irq_a_flag_out = control_q[`CTL_A_IRQ_FLAG];
  assign ext_irq_b_flag_out = control_q[`CTL_B_IRQ_FLAG];

  // ==========================================================
  // checks
  sequence s_a_roll16;
    clk_en_in && inc_a && mode_a == mode_16bit && {a_high_q, a_low_q} == 16'hffff;
  endsequence
  a_flag_on_roll: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    s_a_roll16 |=> unit_a_overflow_flag_out && a_low_q == 8'h00)
    else $error("overflow flag not set on rollover");
  a_run_stops_count: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    (clk_en_in && !control_q[`CTL_A_RUN] && !wr_a_low && !wr_a_high && !split_on)
      |=> $stable(a_low_q) && $stable(a_high_q))
    else $error("unit a counted while stopped");
  a_reload_low: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    (clk_en_in && inc_a && mode_a == mode_8bit_reload && a_low_q == 8'hff
      && !wr_a_low && !wr_a_high)
      |=> a_low_q == $past(a_high_q) && $stable(a_high_q))
    else $error("reload value not copied");
  a_split_b_flag: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    (clk_en_in && ovf_a_high) |=> unit_b_overflow_flag_out)
    else $error("split high overflow missed unit b flag");
  a_baud_tick: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    (clk_en_in && ovf_b) |=> baud_tick_out)
    else $error("baud tick missing");
  a_pin_edge_count: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    (clk_en_in && en_a && mode_q[`MOD_A_CNT] && mode_a == mode_16bit && !cnt_a_fall
      && !wr_a_low && !wr_a_high) |=> $stable(a_low_q))
    else $error("counted without pin edge");
  a_level_irq: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    (clk_en_in && !control_d[`CTL_A_IRQ_TYPE] && !wr_control)
      |=> ext_irq_a_flag_out == $past(gate_a_active))
    else $error("level irq flag does not follow pin");
  a_b_stops_mode3: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    (clk_en_in && mode_b == mode_split && !wr_b_low && !wr_b_high)
      |=> $stable(b_low_q) && $stable(b_high_q))
    else $error("unit b moved in mode 3");
endmodule // dual_legacy_counter_timer

// >>> logic/legacy_timer_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef LEGACY_TIMER_REGS_SVH
`define LEGACY_TIMER_REGS_SVH
// ==========================================================
// register offsets (8-bit address space)
`define OFS_CONTROL 8'h88
`define OFS_MODE 8'h89
`define OFS_A_LOW 8'h8a
`define OFS_B_LOW 8'h8b
`define OFS_A_HIGH 8'h8c
`define OFS_B_HIGH 8'h8d
`define OFS_CLOCK_CFG 8'h8e
`define OFS_PIN_CFG 8'h8f
// ==========================================================
// control register fields
`define CTL_B_FLAG 7
`define CTL_B_RUN 6
`define CTL_A_FLAG 5
`define CTL_A_RUN 4
`define CTL_B_IRQ_FLAG 3
`define CTL_B_IRQ_TYPE 2
`define CTL_A_IRQ_FLAG 1
`define CTL_A_IRQ_TYPE 0
// mode register fields
`define MOD_B_GATE 7
`define MOD_B_CNT 6
`define MOD_A_GATE 3
`define MOD_A_CNT 2
`define MOD_B_LSB 4
`define MOD_A_LSB 0
// clock config fields: unit clock selects and prescale
`define CKC_B_SYS 3
`define CKC_A_SYS 2
`define CKC_PRE_LSB 0
// pin config fields: gate polarities (1 = active high)
`define PIN_B_POL 1
`define PIN_A_POL 0
// ==========================================================
// reset values
`define RST_BYTE 8'h00
// prescale divisors
`define DIV_BY_4 6'd4
`define DIV_BY_48 6'd48
`define DIV_BY_8 6'd8
`define DIV_BY_12 6'd12
`endif

// >>> logic/legacy_timer_pkg.sv
// types shared by the dual legacy counter/timer
package legacy_timer_pkg;
  typedef enum logic [1:0] {
    mode_13bit,
    mode_16bit,
    mode_8bit_reload,
    mode_split
  } timer_mode_type;
  typedef logic [7:0] byte_type;
endpackage

// >>> verif/pin_source.sv
// behavioural source for the count, gate and external clock pins
`timescale 1ns/100ps

module pin_source
(
  input wire logic clk_sys_in,
  output logic count_pin_a_out,
  output logic count_pin_b_out,
  output logic gate_input_a_out,
  output logic gate_input_b_out,
  output logic ext_clk_out
);
  // ==========================================
  // idle levels: count pins high, gates inactive (active low at reset)
  initial
  begin
    count_pin_a_out = 1'b1;
    count_pin_b_out = 1'b1;
    gate_input_a_out = 1'b1;
    gate_input_b_out = 1'b1;
    ext_clk_out = 1'b0;
  end

  // free external clock, eight system cycles a period
  always
  begin
    repeat (4) @(posedge clk_sys_in);
    ext_clk_out <= ~ext_clk_out;
  end

  // ==========================================
  // each level held three cycles
  task automatic pulse(input bit sel_b, input int n);
    repeat (n)
    begin
      @(posedge clk_sys_in);
      if (sel_b) count_pin_b_out <= 1'b0;
      else count_pin_a_out <= 1'b0;
      repeat (3) @(posedge clk_sys_in);
      if (sel_b) count_pin_b_out <= 1'b1;
      else count_pin_a_out <= 1'b1;
      repeat (2) @(posedge clk_sys_in);
    end
  endtask

  // gate level change, launched after an edge
  task automatic set_gate(input bit sel_b, input logic lvl);
    @(posedge clk_sys_in);
    if (sel_b) gate_input_b_out <= lvl;
    else gate_input_a_out <= lvl;
  endtask
endmodule // pin_source

// >>> verif/dual_legacy_counter_timer_bench.sv
// self-checking bench for the dual legacy counter/timer
`timescale 1ns/100ps

module dual_legacy_counter_timer_bench;
  import legacy_timer_pkg::*;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_type;
  logic clk_sys_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [7:0] addr = 8'h00;
  byte_type wdata = 8'h00;
  logic wr_s = 1'b0, rd_s = 1'b0;
  logic vec_a = 1'b0, vec_b = 1'b0, virq_a = 1'b0, virq_b = 1'b0;
  logic ce = 1'b1;
  byte_type rdata;
  logic baud_tick, ua_flag, ub_flag, xa_flag, xb_flag;
  logic cnt_a, cnt_b, gate_a, gate_b, ext_clk;
  int n_fail = 0;
  int checked = 0;
  // mode, counts, clock and pin config, unmapped, control
  row_type rows[11] = '{'{8'h89, 8'ha5, 8'ha5}, '{8'h89, 8'h00, 8'h00},
    '{8'h8a, 8'h3c, 8'h3c}, '{8'h8b, 8'hc3, 8'hc3}, '{8'h8c, 8'h5a, 8'h5a},
    '{8'h8d, 8'ha5, 8'ha5}, '{8'h8e, 8'h0e, 8'h0e}, '{8'h8f, 8'h00, 8'h00},
    '{8'h90, 8'hff, 8'h00}, '{8'h88, 8'h04, 8'h04}, '{8'h88, 8'h00, 8'h00}};
  // timer clock: clock config and run span giving ten counts
  logic [7:0] cfg[5] = '{8'h04, 8'h01, 8'h00, 8'h02, 8'h03};
  int cyc[5] = '{8, 38, 118, 478, 638};

  always #5 clk_sys_in = ~clk_sys_in;

  // ==========================================
  // design and pin partner
  dual_legacy_counter_timer dut (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
    .clk_en_in(ce), .addr_in(addr), .wdata_in(wdata), .wr_in(wr_s), .rd_in(rd_s),
    .rdata_out(rdata), .count_pin_a_in(cnt_a), .count_pin_b_in(cnt_b),
    .gate_input_a_in(gate_a), .gate_input_b_in(gate_b), .ext_clk_in(ext_clk),
    .vector_a_in(vec_a), .vector_b_in(vec_b), .vector_irq_a_in(virq_a),
    .vector_irq_b_in(virq_b), .baud_tick_out(baud_tick),
    .unit_a_overflow_flag_out(ua_flag), .unit_b_overflow_flag_out(ub_flag),
    .ext_irq_a_flag_out(xa_flag), .ext_irq_b_flag_out(xb_flag));
  pin_source pins (.clk_sys_in(clk_sys_in), .count_pin_a_out(cnt_a),
    .count_pin_b_out(cnt_b), .gate_input_a_out(gate_a), .gate_input_b_out(gate_b),
    .ext_clk_out(ext_clk));

  // ==========================================
  // bus cycles and comparisons
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk_sys_in);
    wr_s <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys_in);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk_sys_in);
    rd_s <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic expect_val(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    expect_val(d, e);
  endtask

  function automatic logic pick(input int w);
    case (w)
      0: return ua_flag;
      1: return ub_flag;
      2: return xa_flag;
      3: return baud_tick;
      default: return xb_flag;
    endcase
  endfunction

  // settled flag level a few cycles on, past the pin synchronisers
  task automatic flag(input int w, input logic e);
    repeat (5) @(posedge clk_sys_in);
    #1;
    expect_val({7'h00, pick(w)}, {7'h00, e});
  endtask

  // bounded wait, so a missing event fails instead of hanging
  task automatic wait_sig(input int w, input int lim);
    for (int i = 0; i < lim; i++)
    begin
      @(posedge clk_sys_in);
      #1;
      if (pick(w) === 1'b1) break;
    end
    expect_val({7'h00, pick(w)}, 8'h01);
  endtask

  task automatic reset_vals();
    for (int i = 8'h88; i <= 8'h8f; i++) chk(i[7:0], 8'h00);
  endtask

  task automatic finish_test();
    if (n_fail == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // watchdog, well past the expected few thousand cycles
  initial
  begin
    #500000;
    n_fail++;
    $display("[ERR] %0t watchdog expired", $time);
    finish_test();
  end

  // ==========================================
  // main sequence
  initial
  begin
    logic [7:0] d;
    repeat (16) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    reset_vals();
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      chk(rows[i].a, rows[i].e);
    end
    // timer clock sources, one count window each
    wr(8'h89, 8'h01);
    for (int k = 0; k < 5; k++)
    begin
      wr(8'h8e, cfg[k]);
      wr(8'h8a, 8'h00);
      wr(8'h88, 8'h10);
      repeat (cyc[k]) @(posedge clk_sys_in);
      wr(8'h88, 8'h00);
      rd(8'h8a, d);
      expect_val({7'h00, d >= 8'd9 && d <= 8'd11}, 8'h01);
    end
    // 13-bit rollover from low bits 4..0 all ones, vector clear
    wr(8'h8e, 8'h04);
    wr(8'h89, 8'h00);
    wr(8'h8a, 8'hff);
    wr(8'h8c, 8'hff);
    wr(8'h88, 8'h10);
    wait_sig(0, 20);
    @(posedge clk_sys_in);
    vec_a <= 1'b1;
    @(posedge clk_sys_in);
    vec_a <= 1'b0;
    flag(0, 1'b0);
    wr(8'h88, 8'h00);
    chk(8'h8c, 8'h00);
    // 16-bit: low 1f, high ff take 225 counts to roll over
    wr(8'h89, 8'h01);
    wr(8'h8a, 8'h1f);
    wr(8'h8c, 8'hff);
    wr(8'h88, 8'h10);
    repeat (100) @(posedge clk_sys_in);
    flag(0, 1'b0);
    wait_sig(0, 300);
    wr(8'h88, 8'h00);
    flag(0, 1'b0);
    // 8-bit auto-reload
    wr(8'h89, 8'h02);
    wr(8'h8c, 8'hf0);
    wr(8'h8a, 8'hfe);
    wr(8'h88, 8'h10);
    wait_sig(0, 20);
    wr(8'h88, 8'h00);
    chk(8'h8c, 8'hf0);
    rd(8'h8a, d);
    expect_val({4'h0, d[7:4]}, 8'h0f);
    // gated run: value kept until gate active; level irq flag
    wr(8'h89, 8'h09);
    wr(8'h8a, 8'h40);
    wr(8'h88, 8'h10);
    repeat (20) @(posedge clk_sys_in);
    chk(8'h8a, 8'h40);
    pins.set_gate(0, 1'b0);
    flag(2, 1'b1);
    pins.set_gate(0, 1'b1);
    flag(2, 1'b0);
    wr(8'h88, 8'h00);
    rd(8'h8a, d);
    expect_val({7'h00, d > 8'h40}, 8'h01);
    // edge irq flag, cleared on vector while input stays active
    wr(8'h88, 8'h01);
    pins.set_gate(0, 1'b0);
    flag(2, 1'b1);
    @(posedge clk_sys_in);
    virq_a <= 1'b1;
    @(posedge clk_sys_in);
    virq_a <= 1'b0;
    flag(2, 1'b0);
    pins.set_gate(0, 1'b1);
    // counts loaded before enabling; falling pin edges counted
    wr(8'h88, 8'h00);
    wr(8'h89, 8'h55);
    wr(8'h8a, 8'h00);
    wr(8'h8b, 8'h00);
    wr(8'h88, 8'h50);
    pins.pulse(0, 5);
    pins.pulse(1, 3);
    repeat (6) @(posedge clk_sys_in);
    chk(8'h8a, 8'h05);
    chk(8'h8b, 8'h03);
    // split mode: high byte runs on unit b run and flag
    wr(8'h88, 8'h00);
    wr(8'h8e, 8'h0c);
    wr(8'h8a, 8'h20);
    wr(8'h8c, 8'hfe);
    wr(8'h8b, 8'h10);
    wr(8'h89, 8'h33);
    wr(8'h88, 8'h40);
    wait_sig(1, 20);
    @(posedge clk_sys_in);
    vec_b <= 1'b1;
    @(posedge clk_sys_in);
    vec_b <= 1'b0;
    flag(1, 1'b0);
    chk(8'h8b, 8'h10);
    chk(8'h8a, 8'h20);
    wr(8'h88, 8'h00);
    wr(8'h8d, 8'hff);
    wr(8'h8b, 8'hf0);
    wr(8'h89, 8'h13);
    wait_sig(3, 60);
    flag(1, 1'b0);
    wr(8'h89, 8'h00);
    // unit b gated by its own input, active high: counts E3..E10 of run
    wr(8'h8f, 8'h02);
    wr(8'h89, 8'h90);
    wr(8'h8b, 8'h00);
    wr(8'h88, 8'h40);
    flag(4, 1'b1);
    pins.set_gate(1, 1'b0);
    flag(4, 1'b0);
    chk(8'h8b, 8'h08);
    // edge flag b set on move into active level, cleared on vector
    wr(8'h88, 8'h04);
    pins.set_gate(1, 1'b1);
    flag(4, 1'b1);
    @(posedge clk_sys_in);
    virq_b <= 1'b1;
    @(posedge clk_sys_in);
    virq_b <= 1'b0;
    flag(4, 1'b0);
    // clock enable low freezes the count: three counts instead of 23
    wr(8'h8a, 8'h00);
    wr(8'h88, 8'h10);
    @(posedge clk_sys_in);
    ce <= 1'b0;
    repeat (20) @(posedge clk_sys_in);
    ce <= 1'b1;
    wr(8'h88, 8'h00);
    chk(8'h8a, 8'h03); // clock enable freeze
    // second reset in mid-run
    @(posedge clk_sys_in);
    resetn_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    reset_vals();
    finish_test();
  end
endmodule // dual_legacy_counter_timer_bench
